// ===== hdl/noise_rng_pkg.sv
package noise_rng_pkg;
	// Register byte offsets
	localparam logic [11:0] OFS_START = 12'h000;
	localparam logic [11:0] OFS_STOP = 12'h004;
	localparam logic [11:0] OFS_EVENT = 12'h100;
	localparam logic [11:0] OFS_SHORT = 12'h200;
	localparam logic [11:0] OFS_IEN_SET = 12'h304;
	localparam logic [11:0] OFS_IEN_CLR = 12'h308;
	localparam logic [11:0] OFS_CONFIG = 12'h504;
	localparam logic [11:0] OFS_VALUE = 12'h508;
	// Field positions (all single-bit fields sit in bit 0)
	localparam int TRIG_BIT = 0;
	localparam int EVENT_BIT = 0;
	localparam int HALT_LINK_BIT = 0;
	localparam int IEN_BIT = 0;
	localparam int BIAS_EN_BIT = 0;
	// Reset values
	localparam logic RST_EVENT = 1'h0;
	localparam logic RST_HALT_LINK = 1'h0;
	localparam logic RST_IEN = 1'h0;
	localparam logic RST_BIAS_EN = 1'h0;
	localparam logic [7:0] RST_VALUE = 8'h00;
	// Byte assembly width
	localparam int BYTE_W = 8;
	// Timing counts, in REF_CLK cycles, and queue depth in bytes
	localparam int SAMPLE_DIV_DEF = 4;
	localparam int OUT_GAP_DEF = 8;
	localparam int FIFO_DEPTH_DEF = 4;
	// Generator states
	typedef enum logic {GEN_IDLE, GEN_RUN} gen_state_t;
endpackage

// ===== hdl/noise_rng.sv
// How it works
// RL1: start trigger write begins continuous generation
// RL2: stop trigger write halts generation until restart
// RL3: each finished byte lands in output register
// RL4: value-ready flag set per new output value
// RL5: software reads value before next event
// RL6: optional bias correction on raw noise bits
// RL7: bits shift into eight-bit assembly register
// RL8: configuration register enables bias correction
// RL9: byte generation time varies, no fixed latency; with bias correction off the code takes a fixed eight samples per byte
// RL10: randomness from noise source, no seed
// RL11: shortcut register links events to tasks
// RL12: ready-to-halt link stops after each value
// RL13: enable-set register enables interrupt, reads state
// RL14: enable-clear register disables interrupt, reads state
// RL15: configuration bit 0 selects bias correction
// RL16: interrupt asserted while flag set and enabled
// RL17: reset clears value, flag; generator idles
`timescale 1ns/10ps
// Small synchronous FIFO with valid/ready on both sides
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage words
	logic [PW-1:0] wr_ptr_r; // Next slot to fill
	logic [PW-1:0] rd_ptr_r; // Oldest slot
	logic [CW-1:0] cnt_r; // Words held
	logic push; // Word accepted this cycle
	logic pop; // Word delivered this cycle
	assign in_ready = (cnt_r != FULL_CNT);
	assign out_valid = (cnt_r != '0);
	assign out_data = mem[rd_ptr_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Pointer step with wrap for depths that are not powers of two
	function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
		step = (p == LAST_PTR) ? '0 : p + 1'b1;
	endfunction
	// Storage is not reset; count gates every read
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	// Pointers and count; clear empties the queue at once
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r <= '0;
		end else if (clr) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= step(wr_ptr_r);
			end
			if (pop) begin
				rd_ptr_r <= step(rd_ptr_r);
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule
// Noise-driven random byte generator with APB register bank
module noise_rng
	import noise_rng_pkg::*;
#(
	parameter int SAMPLE_DIV = SAMPLE_DIV_DEF,
	parameter int OUT_GAP = OUT_GAP_DEF,
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic NOISE_IN,
	output logic IRQ
);
	localparam int SW = $clog2(SAMPLE_DIV + 1);
	localparam int GW = $clog2(OUT_GAP + 1);
	localparam logic [SW-1:0] SAMPLE_LAST = SW'(SAMPLE_DIV - 1);
	localparam logic [GW-1:0] GAP_LOAD = GW'(OUT_GAP);
	// Offset decode, used by read and write paths
	function automatic logic hit(input logic [11:0] a,
		input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction
	// Address is one of the eight mapped words
	function automatic logic mapped(input logic [11:0] a);
		mapped = hit(a, OFS_START) || hit(a, OFS_STOP) ||
			hit(a, OFS_EVENT) || hit(a, OFS_SHORT) ||
			hit(a, OFS_IEN_SET) || hit(a, OFS_IEN_CLR) ||
			hit(a, OFS_CONFIG) || hit(a, OFS_VALUE);
	endfunction
	// Bus handshake state
	logic pready_r; // One wait state per access
	logic [31:0] prdata_r; // Read data held for the master
	logic pslverr_r; // Unmapped address answer
	logic acc; // Access completes on this edge
	logic wr; // Completing write
	// Software-visible state
	logic event_r; // Value-ready flag
	logic halt_link_r; // Ready-to-halt shortcut
	logic ien_r; // Interrupt enable
	logic bias_en_r; // Bias correction enable
	logic [7:0] value_r; // Output random byte
	logic irq_r; // Registered interrupt
	// Generator state
	gen_state_t state_r; // Idle or running
	gen_state_t state_nxt; // Next generator state
	logic start_hit; // Software start trigger
	logic stop_hit; // Software or shortcut stop
	logic noise_s1_r; // Noise synchroniser, first stage
	logic noise_s2_r; // Noise synchroniser, second stage
	logic [SW-1:0] samp_cnt_r; // Sample spacing counter
	logic samp; // Sample strobe
	logic pair_have_r; // First bit of a pair held
	logic pair_bit_r; // That first bit
	logic bit_ok; // Corrected bit available
	logic bit_val; // Its value
	logic [BYTE_W-1:0] shift_r; // Assembly register
	logic [2:0] bit_cnt_r; // Bits collected so far
	logic byte_full_r; // Assembly register holds a byte
	logic fifo_in_ready; // Queue can take the byte
	logic fifo_out_valid; // Queue has a byte
	logic [BYTE_W-1:0] fifo_out_data; // Oldest queued byte
	logic drain; // Byte moves to output register
	logic [GW-1:0] gap_cnt_r; // Output pacing counter
	logic running; // Generator active
	assign acc = PSEL && PENABLE && pready_r;
	assign wr = acc && PWRITE;
	assign running = (state_r == GEN_RUN);
	assign start_hit = wr && hit(PADDR, OFS_START) && PWDATA[TRIG_BIT];
	// Stop comes from software or from the shortcut on a new value
	assign stop_hit = (wr && hit(PADDR, OFS_STOP) && PWDATA[TRIG_BIT]) ||
		(drain && halt_link_r); // RL12 RL11
	assign PREADY = pready_r;
	assign PRDATA = prdata_r;
	assign PSLVERR = pslverr_r;
	assign IRQ = irq_r;
	// Ready rises one cycle into the access phase, then drops
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			pready_r <= 1'b0;
		end else begin
			pready_r <= PSEL && PENABLE && !pready_r;
		end
	end

	// Read data and error are prepared in the wait cycle
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			prdata_r <= '0;
			pslverr_r <= 1'b0;
		end else if (PSEL && PENABLE && !pready_r) begin
			pslverr_r <= !mapped(PADDR);
			prdata_r <= '0;
			if (!PWRITE) begin
				unique case (1'b1)
					hit(PADDR, OFS_EVENT): begin
						prdata_r[EVENT_BIT] <= event_r;
					end
					hit(PADDR, OFS_SHORT): begin
						prdata_r[HALT_LINK_BIT] <= halt_link_r;
					end
					// Both enable registers show the same state
					hit(PADDR, OFS_IEN_SET),
					hit(PADDR, OFS_IEN_CLR): begin
						prdata_r[IEN_BIT] <= ien_r; // RL13 RL14
					end
					hit(PADDR, OFS_CONFIG): begin
						prdata_r[BIAS_EN_BIT] <= bias_en_r;
					end
					hit(PADDR, OFS_VALUE): begin
						prdata_r[BYTE_W-1:0] <= value_r;
					end
					// Triggers and unmapped words read zero
					default: begin
						prdata_r <= '0;
					end
				endcase
			end
		end else begin
			pslverr_r <= 1'b0;
		end
	end

	// Shortcut and configuration registers
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			halt_link_r <= RST_HALT_LINK; // RL12
			bias_en_r <= RST_BIAS_EN; // RL15
		end else if (wr) begin
			if (hit(PADDR, OFS_SHORT)) begin
				halt_link_r <= PWDATA[HALT_LINK_BIT]; // RL11
			end
			if (hit(PADDR, OFS_CONFIG)) begin
				bias_en_r <= PWDATA[BIAS_EN_BIT]; // RL8 RL15
			end
		end
	end

	// Interrupt enable: ones set or clear, zeros do nothing
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			ien_r <= RST_IEN;
		end else if (wr && hit(PADDR, OFS_IEN_SET) && PWDATA[IEN_BIT]) begin
			ien_r <= 1'b1; // RL13
		end else if (wr && hit(PADDR, OFS_IEN_CLR) && PWDATA[IEN_BIT]) begin
			ien_r <= 1'b0; // RL14
		end
	end

	// Value-ready flag; a new value wins over a software clear
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			event_r <= RST_EVENT; // RL17
		end else if (drain) begin
			event_r <= 1'b1; // RL4
		end else if (wr && hit(PADDR, OFS_EVENT) && !PWDATA[EVENT_BIT]) begin
			event_r <= 1'b0; // RL16
		end
	end

	// Interrupt is a registered copy of flag and enable
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= event_r && ien_r; // RL16
		end
	end

	// Start wins over a stop in the same cycle
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			GEN_IDLE: begin
				if (start_hit) begin
					state_nxt = GEN_RUN; // RL1
				end
			end
			GEN_RUN: begin
				if (stop_hit && !start_hit) begin
					state_nxt = GEN_IDLE; // RL2
				end
			end
		endcase
	end

	// Generator state; idles after reset until started
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			state_r <= GEN_IDLE; // RL17
		end else begin
			state_r <= state_nxt;
		end
	end

	// Noise arrives on the NOISE_IN pin; two flops tame it
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			noise_s1_r <= 1'b0;
			noise_s2_r <= 1'b0;
		end else begin
			noise_s1_r <= NOISE_IN; // RL10
			noise_s2_r <= noise_s1_r;
		end
	end

	// Sample spacing lets the noise decorrelate between bits;
	// sampling pauses while the assembled byte waits for room
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			samp_cnt_r <= '0;
		end else if (!running || byte_full_r || samp) begin
			samp_cnt_r <= '0;
		end else begin
			samp_cnt_r <= samp_cnt_r + 1'b1;
		end
	end
	assign samp = running && !byte_full_r && (samp_cnt_r == SAMPLE_LAST);
	// Pair-wise correction: 01 gives 0, 10 gives 1, equal pairs
	// are dropped, so byte time depends on the noise itself
	always_comb begin
		bit_ok = 1'b0;
		bit_val = noise_s2_r;
		if (samp) begin
			if (!bias_en_r) begin
				bit_ok = 1'b1; // RL6
			end else if (pair_have_r && (pair_bit_r != noise_s2_r)) begin
				bit_ok = 1'b1; // RL6 RL9
				bit_val = pair_bit_r;
			end
		end
	end
	// First-bit store for the correction pairs
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			pair_have_r <= 1'b0;
			pair_bit_r <= 1'b0;
		end else if (!running || !bias_en_r) begin
			pair_have_r <= 1'b0;
		end else if (samp) begin
			pair_have_r <= !pair_have_r;
			pair_bit_r <= noise_s2_r;
		end
	end

	// Bits shift into the assembly register, eight make a byte
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			shift_r <= '0;
			bit_cnt_r <= '0;
			byte_full_r <= 1'b0;
		end else if (!running || start_hit) begin
			bit_cnt_r <= '0;
			byte_full_r <= 1'b0;
		end else if (byte_full_r) begin
			if (fifo_in_ready) begin
				byte_full_r <= 1'b0;
			end
		end else if (bit_ok) begin
			shift_r <= {shift_r[BYTE_W-2:0], bit_val}; // RL7
			bit_cnt_r <= bit_cnt_r + 1'b1;
			if (bit_cnt_r == 3'h7) begin
				byte_full_r <= 1'b1; // RL7
			end
		end
	end

	// Queue between assembly and output; flushed on stop or restart
	byte_fifo #(
		.WIDTH(BYTE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(REF_CLK),
		.rst(RST),
		.clr(!running || start_hit),
		.in_valid(byte_full_r),
		.in_ready(fifo_in_ready),
		.in_data(shift_r),
		.out_valid(fifo_out_valid),
		.out_ready(running && gap_cnt_r == '0),
		.out_data(fifo_out_data)
	);
	// A queued byte moves out once the pacing gap has elapsed
	assign drain = fifo_out_valid && running && (gap_cnt_r == '0) &&
		!start_hit;
	// Pacing gap: the queue fills when noise outruns this rate
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			gap_cnt_r <= '0;
		end else if (drain) begin
			gap_cnt_r <= GAP_LOAD;
		end else if (gap_cnt_r != '0) begin
			gap_cnt_r <= gap_cnt_r - 1'b1;
		end
	end

	// Output register is overwritten by every new byte; the queue
	// feeding it never waits for a read, so a slow reader loses the older value
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			value_r <= RST_VALUE; // RL17
		end else if (drain) begin
			value_r <= fifo_out_data; // RL3 RL5
		end
	end
endmodule

// ===== tb/noise_source.sv
`timescale 1ns/10ps
// Stand-in for the analogue noise cell: constant or a known toggle
module noise_source #(
	parameter int DIV = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] mode,
	output logic noise
);
	logic [7:0] cnt_r; // Toggle period counter
	logic tog_r; // Alternating level
	// Toggle once per sample period so each sample sees a fresh level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 8'h00;
			tog_r <= 1'b0;
		end else if (cnt_r == 8'(DIV - 1)) begin
			cnt_r <= 8'h00;
			tog_r <= ~tog_r;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
	// No seed anywhere: the pin is the only source of bits
	assign noise = (mode == 2'h2) ? tog_r : mode[0];
endmodule

// ===== tb/noise_rng_asserts.sv
`timescale 1ns/10ps
// Port-level checks; shadows track software-visible state
module noise_rng_asserts
	import noise_rng_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic NOISE_IN,
	input wire logic IRQ
);
	logic wr_ok, rd_ok, mapped; // Completed accesses, decode
	logic ien_r, cfg_r, link_r, started_r; // Shadow state
	assign wr_ok = PSEL && PENABLE && PREADY && PWRITE;
	assign rd_ok = PSEL && PENABLE && PREADY && !PWRITE;
	assign mapped = PADDR inside {OFS_START, OFS_STOP, OFS_EVENT, OFS_SHORT,
		OFS_IEN_SET, OFS_IEN_CLR, OFS_CONFIG, OFS_VALUE};
	// Interrupt enable shadow: set and clear only on a written one
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			ien_r <= 1'b0;
		end else if (wr_ok && PADDR == OFS_IEN_SET && PWDATA[0]) begin
			ien_r <= 1'b1;
		end else if (wr_ok && PADDR == OFS_IEN_CLR && PWDATA[0]) begin
			ien_r <= 1'b0;
		end
	end
	// Plain read/write shadows and a seen-start marker
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			cfg_r <= 1'b0;
			link_r <= 1'b0;
			started_r <= 1'b0;
		end else if (wr_ok) begin
			if (PADDR == OFS_CONFIG) cfg_r <= PWDATA[0];
			if (PADDR == OFS_SHORT) link_r <= PWDATA[0];
			if (PADDR == OFS_START && PWDATA[0]) started_r <= 1'b1;
		end
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	ready_pulse_a: assert property (PREADY |=> !PREADY)
		else $error("ready held past one cycle");
	ready_wait_a: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
		else $error("ready not one wait after access");
	err_map_a: assert property (PREADY |-> PSLVERR == !mapped)
		else $error("error response wrong for address");
	trig_read_a: assert property (rd_ok && (PADDR == OFS_START ||
		PADDR == OFS_STOP) |-> PRDATA == 32'h0) else $error("trigger read");
	value_width_a: assert property (rd_ok && PADDR == OFS_VALUE |->
		PRDATA[31:8] == 24'h0) else $error("value above byte");
	idle_value_a: assert property (rd_ok && PADDR == OFS_VALUE &&
		!started_r |-> PRDATA == 32'h0) else $error("value before start");
	ien_read_a: assert property (rd_ok && (PADDR == OFS_IEN_SET ||
		PADDR == OFS_IEN_CLR) |-> PRDATA == {31'h0, ien_r})
		else $error("enable readback");
	cfg_read_a: assert property (rd_ok && PADDR == OFS_CONFIG |->
		PRDATA == {31'h0, cfg_r}) else $error("config readback");
	link_read_a: assert property (rd_ok && PADDR == OFS_SHORT |->
		PRDATA == {31'h0, link_r}) else $error("shortcut readback");
	irq_mask_a: assert property (IRQ |-> $past(ien_r))
		else $error("interrupt while disabled");
	cover property (wr_ok && PADDR == OFS_START);
	cover property (IRQ);
	cover property (PREADY && PSLVERR);
endmodule

bind noise_rng noise_rng_asserts noise_rng_asserts_inst (.REF_CLK(REF_CLK),
	.RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .NOISE_IN(NOISE_IN), .IRQ(IRQ));

// ===== tb/test_thermal_noise_rng.sv
`timescale 1ns/10ps
module test_thermal_noise_rng;
	import noise_rng_pkg::*;
	typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d;
		logic [31:0] e; logic err;} row_t;
	logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, noise, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_v;
	logic [1:0] mode; // Noise pattern select
	logic er_v;
	int err_total = 0;
	int check_count = 0;
	// Register cases: write, address, data, expected read, error
	row_t rows [21] = '{'{0, OFS_CONFIG, 0, 0, 0}, '{0, OFS_SHORT, 0, 0, 0},
		'{0, OFS_IEN_SET, 0, 0, 0}, '{0, OFS_EVENT, 0, 0, 0},
		'{0, OFS_VALUE, 0, 0, 0}, '{0, OFS_START, 0, 0, 0},
		'{1, OFS_CONFIG, 1, 0, 0}, '{0, OFS_CONFIG, 0, 1, 0},
		'{1, OFS_CONFIG, 0, 0, 0}, '{1, OFS_IEN_SET, 0, 0, 0},
		'{0, OFS_IEN_CLR, 0, 0, 0}, '{1, OFS_IEN_SET, 1, 0, 0},
		'{0, OFS_IEN_CLR, 0, 1, 0}, '{1, OFS_IEN_CLR, 1, 0, 0},
		'{0, OFS_IEN_SET, 0, 0, 0}, '{1, OFS_VALUE, 32'hFF, 0, 0},
		'{0, OFS_VALUE, 0, 0, 0}, '{0, 12'h00C, 0, 0, 1},
		'{1, OFS_SHORT, 1, 0, 0}, '{0, OFS_SHORT, 0, 1, 0},
		'{1, OFS_SHORT, 0, 0, 0}};
	noise_rng #(.SAMPLE_DIV(SAMPLE_DIV_DEF), .OUT_GAP(OUT_GAP_DEF),
		.FIFO_DEPTH(FIFO_DEPTH_DEF)) noise_rng_inst (.REF_CLK(ref_clk),
		.RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .NOISE_IN(noise), .IRQ(irq));
	noise_source #(.DIV(SAMPLE_DIV_DEF)) noise_source_inst (.clk(ref_clk),
		.rst(rst), .mode(mode), .noise(noise));
	// Verdict in one place
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One APB transfer; entered at a rising edge, leaves one idle edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			chk("pready", 0, 1);
			end_sim();
		end
		rd_v = prdata;
		er_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd_chk(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, rd_v, e);
	endtask
	// Poll the event flag; byte time varies under bias correction so only a bound is used
	task automatic wait_flag();
		int n;
		n = 0;
		do begin
			apb(1'b0, OFS_EVENT, 32'h0);
			n++;
		end while (rd_v[0] !== 1'b1 && n < 200);
		if (n >= 200) begin
			chk("ready_flag", 0, 1);
			end_sim();
		end
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		mode = 2'h1;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) chk("read", rd_v, rows[i].e);
			chk("slverr", {31'h0, er_v}, {31'h0, rows[i].err});
		end
		$display("register table done");
		apb(1, OFS_IEN_SET, 1);
		apb(1, OFS_START, 1);
		wait_flag();
		rd_chk("value", OFS_VALUE, 32'hFF);
		chk("irq", {31'h0, irq}, 1);
		apb(1, OFS_EVENT, 0);
		wait_flag();
		apb(1, OFS_STOP, 1);
		apb(1, OFS_EVENT, 0);
		repeat (200) @(posedge ref_clk);
		rd_chk("halted", OFS_EVENT, 0);
		chk("irq_low", {31'h0, irq}, 0);
		$display("start stop done");
		mode <= 2'h2;
		for (int b = 0; b < 2; b++) begin
			apb(1, OFS_CONFIG, b);
			apb(1, OFS_START, 1);
			wait_flag();
			apb(1, OFS_STOP, 1);
			apb(1, OFS_EVENT, 0);
			apb(0, OFS_VALUE, 0);
			// Unbiased alternation gives 55/AA; corrected pairs give 00/FF
			if (b == 0) chk("alt", rd_v === 32'hAA || rd_v === 32'h55, 1);
			else chk("corr", rd_v === 32'h0 || rd_v === 32'hFF, 1);
		end
		mode <= 2'h1;
		apb(1, OFS_START, 1);
		repeat (300) @(posedge ref_clk);
		rd_chk("const_drop", OFS_EVENT, 0);
		apb(1, OFS_STOP, 1);
		apb(1, OFS_CONFIG, 0);
		$display("bias done");
		apb(1, OFS_IEN_CLR, 1);
		apb(1, OFS_SHORT, 1);
		apb(1, OFS_START, 1);
		wait_flag();
		chk("irq_masked", {31'h0, irq}, 0);
		apb(1, OFS_EVENT, 0);
		repeat (200) @(posedge ref_clk);
		rd_chk("one_shot", OFS_EVENT, 0);
		$display("shortcut done");
		apb(1, OFS_SHORT, 0);
		apb(1, OFS_START, 1);
		repeat (100) @(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd_chk("rst_value", OFS_VALUE, 0);
		// A start write with the trigger bit clear must not start it
		apb(1, OFS_START, 0);
		repeat (200) @(posedge ref_clk);
		rd_chk("rst_idle", OFS_EVENT, 0);
		$display("reset done");
		end_sim();
	end
endmodule
